// *** rtl/adms_pkg.sv ***
// constants shared by the adc mode sequencer and its timer
// assumes a 250 MHz bus clock and a 32-bit axi4-lite register port
package adms_pkg;
  // ----------------------------------------------------------------
  // register map: word index, byte address is four times the index
  // ----------------------------------------------------------------
  localparam int IDX_W = 6;
  localparam logic [IDX_W-1:0] CTRL_IDX = 6'h00;
  localparam logic [IDX_W-1:0] RESULT_IDX = 6'h02;
  localparam logic [IDX_W-1:0] STATUS_IDX = 6'h05;
  localparam logic [IDX_W-1:0] TRIG_IDX = 6'h07;
  localparam logic [IDX_W-1:0] IRQ_ST_IDX = 6'h0c;
  localparam logic [IDX_W-1:0] IRQ_MASK_IDX = 6'h0d;
  localparam int IDX_LSB = 2;
  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int CTRL_W = 9;
  localparam logic [CTRL_W-1:0] CTRL_RST = 9'h000;
  localparam int CH_LSB = 0;
  localparam int CH_W = 4;
  localparam int DIFF_BIT = 4;
  localparam int GAIN_LSB = 5;
  localparam int GAIN_W = 2;
  localparam int AUTO_BIT = 7;
  localparam int PIPE_BIT = 8;
  localparam int LOW_BYTE_W = 8;
  // ----------------------------------------------------------------
  // result, status and events
  // ----------------------------------------------------------------
  localparam int ADC_W = 12;
  localparam int RES_W = 16;
  localparam logic [RES_W-ADC_W-1:0] RES_PAD = 4'h0;
  localparam logic [RES_W-1:0] RES_RST = 16'h0000;
  localparam int STAT_SETTLE_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;
  localparam int EVT_W = 2;
  localparam int EVT_SETTLE = 0;
  localparam int EVT_READY = 1;
  localparam logic [EVT_W-1:0] EVT_RST = 2'h0;
  // ----------------------------------------------------------------
  // bus answers
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int SETTLE_NS = 10000;
  localparam int CONV_NOPIPE_NS = 20000;
  localparam int CONV_PIPE_NS = 10000;
  localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int CONV_NOPIPE_CYC = (CONV_NOPIPE_NS * CLK_MHZ + 999) / 1000;
  localparam int CONV_PIPE_CYC = (CONV_PIPE_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 16;
endpackage

// *** rtl/adms_sequencer.sv ***
// adc mode sequencer: control, settling and conversion timing,
// result register with optional pipeline, events and axi4-lite slave
// assumes the converter result pins are stable at conversion end
// Behaviour
// - bit 7 auto start, bit 8 pipelined
// - host unpipelined trigger: convert, load same result
// - host pipelined: load previous conversion result
// - auto unpipelined: load current conversion result
// - auto pipelined: load previous conversion result
// - control write bit7 clear: host mode, restart settling
// - settling flag high until interval elapses
// - busy high until result register loaded
// - control write accepted during running conversion
// - host mode: settle and conversion events
// - bit7 set: hardware starts after settling
// - auto busy spans settle and conversion
// - trigger ignored while busy
// - events on flag falling edges, separate lines
// - 12-bit result left-aligned, low nibble zero
module adms_sequencer #(
  parameter int SETTLE_CYC = adms_pkg::SETTLE_CYC,
  parameter int CONV_NOPIPE_CYC = adms_pkg::CONV_NOPIPE_CYC,
  parameter int CONV_PIPE_CYC = adms_pkg::CONV_PIPE_CYC,
  parameter int CNT_W = adms_pkg::CNT_W
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [adms_pkg::ADC_W-1:0] adc_data_in,
  output logic adc_start,
  output logic [adms_pkg::CH_W-1:0] mux_channel,
  output logic mux_differential,
  output logic [adms_pkg::GAIN_W-1:0] gain_select,
  output logic irq,
  output logic settling_done_irq_n,
  output logic data_ready_irq_n
);
  // ----------------------------------------------------------------
  // parameter checks
  // ----------------------------------------------------------------
  localparam int CNT_MAX = (1 << CNT_W) - 1;
  if (SETTLE_CYC < 1 || SETTLE_CYC > CNT_MAX ||
      CONV_NOPIPE_CYC < 1 || CONV_NOPIPE_CYC > CNT_MAX ||
      CONV_PIPE_CYC < 1 || CONV_PIPE_CYC > CNT_MAX) begin : g_chk
    $error("adms_sequencer: interval counts do not fit the counter");
  end

  function automatic logic [adms_pkg::IDX_W-1:0] reg_index(input logic [7:0] a);
    reg_index = a[adms_pkg::IDX_LSB +: adms_pkg::IDX_W];
  endfunction

  function automatic logic is_mapped(input logic [adms_pkg::IDX_W-1:0] i);
    is_mapped = (i == adms_pkg::CTRL_IDX) || (i == adms_pkg::RESULT_IDX) ||
                (i == adms_pkg::STATUS_IDX) || (i == adms_pkg::TRIG_IDX) ||
                (i == adms_pkg::IRQ_ST_IDX) || (i == adms_pkg::IRQ_MASK_IDX);
  endfunction

  // ----------------------------------------------------------------
  // axi4-lite write path
  // ----------------------------------------------------------------
  logic aw_held_reg, w_held_reg, bvalid_reg, wr_fire;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic [1:0] bresp_reg;
  logic [adms_pkg::IDX_W-1:0] wr_idx;

  assign s_axi_awready = !aw_held_reg;
  assign s_axi_wready = !w_held_reg;
  assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
  assign wr_idx = reg_index(aw_addr_reg);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
    end else if (s_axi_awvalid && !aw_held_reg) begin
      aw_held_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      w_held_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
    end else if (s_axi_wvalid && !w_held_reg) begin
      w_held_reg <= 1'b1;
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= adms_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= is_mapped(wr_idx) ? adms_pkg::RESP_OKAY : adms_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  logic [adms_pkg::CTRL_W-1:0] ctrl_reg, ctrl_next;
  logic ctrl_wr, trig_wr;

  assign ctrl_wr = wr_fire && wr_idx == adms_pkg::CTRL_IDX && |w_strb_reg[1:0];
  assign trig_wr = wr_fire && wr_idx == adms_pkg::TRIG_IDX && |w_strb_reg;

  always_comb begin
    ctrl_next = ctrl_reg;
    if (w_strb_reg[0]) begin
      ctrl_next[adms_pkg::LOW_BYTE_W-1:0] = w_data_reg[adms_pkg::LOW_BYTE_W-1:0];
    end
    if (w_strb_reg[1]) begin
      ctrl_next[adms_pkg::PIPE_BIT] = w_data_reg[adms_pkg::PIPE_BIT];
    end
  end

  // a control write with the byte 0 strobe set applies channel, input mode and gain at once
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl_reg <= adms_pkg::CTRL_RST;
    end else if (ctrl_wr) begin
      ctrl_reg <= ctrl_next;
    end
  end

  assign mux_channel = ctrl_reg[adms_pkg::CH_LSB +: adms_pkg::CH_W];
  assign mux_differential = ctrl_reg[adms_pkg::DIFF_BIT];
  assign gain_select = ctrl_reg[adms_pkg::GAIN_LSB +: adms_pkg::GAIN_W];

  // ----------------------------------------------------------------
  // settling and conversion timers
  // ----------------------------------------------------------------
  adms_tmr_if #(.CW(CNT_W)) settle_if ();
  adms_tmr_if #(.CW(CNT_W)) conv_if ();

  adms_timer #(.CW(CNT_W)) u_settle (.ref_clk(ref_clk), .rst(rst), .bus(settle_if));
  adms_timer #(.CW(CNT_W)) u_conv (.ref_clk(ref_clk), .rst(rst), .bus(conv_if));

  logic auto_pend_reg, auto_pend_next, busy_reg, busy_next;
  logic start_host, start_auto, start_conv, start_reg;

  // each control write restarts the settling count
  assign settle_if.start = ctrl_wr;
  assign settle_if.load_count = CNT_W'(SETTLE_CYC);

  // host trigger only in host mode and only while idle
  assign start_host = trig_wr && !busy_reg && !ctrl_reg[adms_pkg::AUTO_BIT];
  // hardware start once settling is over and the converter is free
  assign start_auto = auto_pend_reg && !settle_if.busy && !ctrl_wr && !conv_if.busy;
  assign start_conv = start_host || start_auto;
  assign conv_if.start = start_conv;
  // pipelined conversions run shorter
  assign conv_if.load_count = ctrl_reg[adms_pkg::PIPE_BIT] ?
                              CNT_W'(CONV_PIPE_CYC) : CNT_W'(CONV_NOPIPE_CYC);

  always_comb begin
    auto_pend_next = auto_pend_reg;
    if (ctrl_wr) begin
      auto_pend_next = ctrl_next[adms_pkg::AUTO_BIT];
    end else if (start_auto) begin
      auto_pend_next = 1'b0;
    end
  end

  // busy covers pending settle in auto mode and the conversion itself
  assign busy_next = start_conv || auto_pend_next || conv_if.busy;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      auto_pend_reg <= 1'b0;
      busy_reg <= 1'b0;
      start_reg <= 1'b0;
    end else begin
      auto_pend_reg <= auto_pend_next;
      busy_reg <= busy_next;
      start_reg <= start_conv;
    end
  end

  assign adc_start = start_reg;

  // ----------------------------------------------------------------
  // result path
  // ----------------------------------------------------------------
  logic [adms_pkg::ADC_W-1:0] adc_meta_reg, adc_sync_reg;
  logic [adms_pkg::RES_W-1:0] prev_reg, result_reg, sample_aligned;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      adc_meta_reg <= '0;
      adc_sync_reg <= '0;
    end else begin
      adc_meta_reg <= adc_data_in;
      adc_sync_reg <= adc_meta_reg;
    end
  end

  // left-aligned so software can treat it as a 16-bit value
  assign sample_aligned = {adc_sync_reg, adms_pkg::RES_PAD};

  // pipelined delivery hands out the previous sample
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prev_reg <= adms_pkg::RES_RST;
      result_reg <= adms_pkg::RES_RST;
    end else if (conv_if.done) begin
      prev_reg <= sample_aligned;
      result_reg <= ctrl_reg[adms_pkg::PIPE_BIT] ? prev_reg : sample_aligned;
    end
  end

  // ----------------------------------------------------------------
  // events and interrupt lines
  // ----------------------------------------------------------------
  logic [adms_pkg::EVT_W-1:0] irq_st_reg, irq_mask_reg, evt_set, evt_clr;

  // settle event only in host mode; ready event on busy falling
  assign evt_set[adms_pkg::EVT_SETTLE] = settle_if.done && !ctrl_reg[adms_pkg::AUTO_BIT];
  assign evt_set[adms_pkg::EVT_READY] = busy_reg && !busy_next;
  assign evt_clr = (wr_fire && wr_idx == adms_pkg::IRQ_ST_IDX && w_strb_reg[0]) ?
                   w_data_reg[adms_pkg::EVT_W-1:0] : adms_pkg::EVT_RST;

  // a set in the clearing cycle survives
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq_st_reg <= adms_pkg::EVT_RST;
    end else begin
      irq_st_reg <= (irq_st_reg & ~evt_clr) | evt_set;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq_mask_reg <= adms_pkg::EVT_RST;
    end else if (wr_fire && wr_idx == adms_pkg::IRQ_MASK_IDX && w_strb_reg[0]) begin
      irq_mask_reg <= w_data_reg[adms_pkg::EVT_W-1:0];
    end
  end

  // each event keeps its own request line
  assign irq = |(irq_st_reg & irq_mask_reg);
  assign settling_done_irq_n = !(irq_st_reg[adms_pkg::EVT_SETTLE] &&
                                 irq_mask_reg[adms_pkg::EVT_SETTLE]);
  assign data_ready_irq_n = !(irq_st_reg[adms_pkg::EVT_READY] &&
                              irq_mask_reg[adms_pkg::EVT_READY]);

  // ----------------------------------------------------------------
  // axi4-lite read path
  // ----------------------------------------------------------------
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic [31:0] rd_word;
  logic [adms_pkg::IDX_W-1:0] rd_idx;

  assign rd_idx = reg_index(s_axi_araddr);
  assign s_axi_arready = !rvalid_reg;

  always_comb begin
    rd_word = 32'h0000_0000;
    case (rd_idx)
      adms_pkg::CTRL_IDX: rd_word[adms_pkg::CTRL_W-1:0] = ctrl_reg;
      adms_pkg::RESULT_IDX: rd_word[adms_pkg::RES_W-1:0] = result_reg;
      adms_pkg::STATUS_IDX: begin
        rd_word[adms_pkg::STAT_SETTLE_BIT] = settle_if.busy;
        rd_word[adms_pkg::STAT_BUSY_BIT] = busy_reg;
      end
      adms_pkg::IRQ_ST_IDX: rd_word[adms_pkg::EVT_W-1:0] = irq_st_reg;
      adms_pkg::IRQ_MASK_IDX: rd_word[adms_pkg::EVT_W-1:0] = irq_mask_reg;
      default: rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= adms_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_reg) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_word;
      rresp_reg <= is_mapped(rd_idx) ? adms_pkg::RESP_OKAY : adms_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  AST_HOST_START: assert property (start_host |=> adc_start && busy_reg)
    else $error("host trigger did not start a conversion");
  AST_TRIG_IGNORED: assert property (trig_wr && busy_reg && !start_auto |=> !adc_start)
    else $error("trigger during busy started a conversion");
  AST_SETTLE_SET: assert property (ctrl_wr |=> settle_if.busy ##1 settle_if.busy)
    else $error("settling flag not raised by control write");
  AST_BUSY_FALL: assert property ($fell(busy_reg) |-> $past(conv_if.done))
    else $error("busy cleared without a result load");
  AST_PIPE_LOAD: assert property (conv_if.done && ctrl_reg[adms_pkg::PIPE_BIT]
    |=> result_reg == $past(prev_reg))
    else $error("pipelined load did not deliver previous result");
  AST_NOPIPE_LOAD: assert property (conv_if.done && !ctrl_reg[adms_pkg::PIPE_BIT]
    |=> result_reg == {$past(adc_sync_reg), adms_pkg::RES_PAD})
    else $error("unpipelined load did not deliver current result");
  AST_LOW_NIBBLE: assert property (result_reg[adms_pkg::RES_W-adms_pkg::ADC_W-1:0]
    == adms_pkg::RES_PAD)
    else $error("result low bits not zero");
  AST_AUTO_START: assert property (start_auto |=> adc_start ##1 conv_if.busy)
    else $error("automatic start not issued after settling");
  AST_AUTO_BUSY: assert property (ctrl_wr && ctrl_next[adms_pkg::AUTO_BIT]
    |=> busy_reg throughout settle_if.busy[*2])
    else $error("busy low during automatic settling");
  AST_SETTLE_EVT: assert property ($fell(settle_if.busy) && !settle_if.start &&
    !ctrl_reg[adms_pkg::AUTO_BIT] |=> irq_st_reg[adms_pkg::EVT_SETTLE])
    else $error("settle event missing in host mode");
  AST_READY_EVT: assert property ($fell(busy_reg) |-> irq_st_reg[adms_pkg::EVT_READY])
    else $error("data ready event missing on busy fall");
  AST_CTRL_APPLY: assert property (ctrl_wr && conv_if.busy
    |=> mux_channel == $past(ctrl_next[adms_pkg::CH_LSB +: adms_pkg::CH_W]))
    else $error("control write during conversion not applied");

  COV_HOST_CONV: cover property (start_host ##1 adc_start);
  COV_AUTO_CONV: cover property (start_auto ##1 busy_reg);
  COV_PIPE_LOAD: cover property (conv_if.done && ctrl_reg[adms_pkg::PIPE_BIT]);
  COV_SETTLE_IRQ: cover property (!settling_done_irq_n);
endmodule

// *** rtl/adms_timer.sv ***
// down counter timing one settling or conversion interval
// assumes load_count of at least one; a start restarts the count
module adms_timer #(
  parameter int CW = 16
) (
  input wire logic ref_clk,
  input wire logic rst,
  adms_tmr_if.tmr bus
);
  logic [CW-1:0] cnt_reg;
  logic busy_reg;
  logic done_reg;

  // busy lasts exactly load_count cycles, done pulses as it drops
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt_reg <= '0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else if (bus.start) begin
      cnt_reg <= bus.load_count - CW'(1);
      busy_reg <= 1'b1;
      done_reg <= 1'b0;
    end else if (busy_reg && cnt_reg == '0) begin
      busy_reg <= 1'b0;
      done_reg <= 1'b1;
    end else begin
      cnt_reg <= busy_reg ? cnt_reg - CW'(1) : cnt_reg;
      done_reg <= 1'b0;
    end
  end

  assign bus.busy = busy_reg;
  assign bus.done = done_reg;
endmodule

// *** rtl/adms_tmr_if.sv ***
// interval timer handshake between sequencer and timer
// assumes both ends run on the same clock
interface adms_tmr_if #(parameter int CW = 16);
  logic start;
  logic [CW-1:0] load_count;
  logic busy;
  logic done;
  modport ctrl (output start, output load_count, input busy, input done);
  modport tmr (input start, input load_count, output busy, output done);
endinterface

// *** verification/adms_conv_model.sv ***
// converter stand-in: every start pulse puts a new 12-bit sample on the pins
// assumes the sequencer samples the pins only at conversion end
module adms_conv_model (
  input wire logic ref_clk,
  input wire logic adc_start,
  output logic [11:0] adc_data_in,
  output int starts
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    adc_data_in = 12'h000;
    starts = 0;
  end
  // sample k is 3a5 plus k times 111, so a stale sample never looks fresh
  always @(posedge ref_clk) begin
    if (adc_start === 1'b1) begin
      adc_data_in <= 12'h3a5 + 12'(starts * 12'h111);
      starts <= starts + 1;
    end
  end
endmodule

// *** verification/tb_top.sv ***
// self-checking bench for the adc mode sequencer through its register port
// assumes shortened interval parameters and the converter stand-in model
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] A_CTRL = {adms_pkg::CTRL_IDX, 2'b00};
  localparam logic [7:0] A_RES = {adms_pkg::RESULT_IDX, 2'b00};
  localparam logic [7:0] A_STAT = {adms_pkg::STATUS_IDX, 2'b00};
  localparam logic [7:0] A_TRIG = {adms_pkg::TRIG_IDX, 2'b00};
  localparam logic [7:0] A_IST = {adms_pkg::IRQ_ST_IDX, 2'b00};
  localparam logic [7:0] A_MSK = {adms_pkg::IRQ_MASK_IDX, 2'b00};
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, gain_select;
  logic [31:0] s_axi_rdata;
  logic [11:0] adc_data_in;
  logic [3:0] mux_channel;
  logic adc_start, mux_differential, irq, settling_done_irq_n, data_ready_irq_n;
  int starts, num_errors = 0, num_checks = 0, ncv = 0;
  logic [31:0] d;
  logic [1:0] r;

  always #2 ref_clk = ~ref_clk;

  adms_sequencer #(.SETTLE_CYC(20), .CONV_NOPIPE_CYC(40), .CONV_PIPE_CYC(20)) DUT (
    .ref_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .adc_data_in, .adc_start,
    .mux_channel, .mux_differential, .gain_select, .irq, .settling_done_irq_n,
    .data_ready_irq_n);
  adms_conv_model conv_model (.ref_clk, .adc_start, .adc_data_in, .starts);

  // ----------------------------------------------------------------
  // shared checks and bus cycles
  // ----------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  function automatic logic [31:0] smp(input int k);
    return {16'h0, 12'h3a5 + 12'(k * 12'h111), 4'h0};
  endfunction
  // ready is looked at on the falling edge, where it has settled
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(ad && wd)) begin
      @(negedge ref_clk);
      ad = ad | (s_axi_awvalid & s_axi_awready);
      wd = wd | (s_axi_wvalid & s_axi_wready);
      @(posedge ref_clk);
      if (ad) s_axi_awvalid <= 1'b0;
      if (wd) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b1;
    ad = 1'b0;
    while (!ad) begin
      @(negedge ref_clk);
      ad = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge ref_clk);
    end
    s_axi_bready <= 1'b0;
    chk("bresp", 32'h0, {30'h0, r});
  endtask
  task automatic rd(input logic [7:0] a);
    logic dn;
    dn = 1'b0;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    while (!dn) begin
      @(negedge ref_clk);
      dn = s_axi_arready;
      @(posedge ref_clk);
    end
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    dn = 1'b0;
    while (!dn) begin
      @(negedge ref_clk);
      dn = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge ref_clk);
    end
    s_axi_rready <= 1'b0;
  endtask
  task automatic wait_clear(input int b);
    int i;
    i = 0;
    do begin
      rd(A_STAT);
      i++;
    end while (d[b] !== 1'b0 && i < 200);
    chk("status poll", 32'h0, {31'h0, d[b]});
  endtask
  task automatic conv;
    wr(A_TRIG, 32'h1, 4'hf);
    ncv++;
    wait_clear(adms_pkg::STAT_BUSY_BIT);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    rd(A_CTRL);
    chk("ctrl reset", 32'h0, d);
    rd(A_STAT);
    chk("status reset", 32'h0, d);
    rd(8'hfc);
    chk("unmapped read", 32'h8000_0000, {r, d[29:0]});
    @(negedge ref_clk);
    chk("irq pins reset", 32'h3, {29'h0, irq, settling_done_irq_n, data_ready_irq_n});
  endtask
  task automatic t_dummy;
    wr(A_MSK, 32'h3, 4'h1);
    wr(A_CTRL, 32'h0, 4'h3);
    wait_clear(adms_pkg::STAT_SETTLE_BIT);
    conv();
    conv();
    chk("starts", 32'(ncv), 32'(starts));
    wr(A_IST, 32'h3, 4'h1);
  endtask
  task automatic t_host;
    int k;
    wr(A_CTRL, 32'h55, 4'h3);
    @(negedge ref_clk);
    chk("select", 32'h55, {25'h0, gain_select, mux_differential, mux_channel});
    rd(A_STAT);
    chk("settle busy", 32'h1, d);
    wait_clear(adms_pkg::STAT_SETTLE_BIT);
    rd(A_IST);
    chk("settle event", 32'h1, d);
    @(negedge ref_clk);
    chk("irq lines", 32'h5, {29'h0, irq, settling_done_irq_n, data_ready_irq_n});
    wr(A_IST, 32'h1, 4'h1);
    k = ncv;
    wr(A_TRIG, 32'h1, 4'hf);
    wr(A_TRIG, 32'h1, 4'hf);
    wr(A_CTRL, 32'h3, 4'h3);
    rd(A_STAT);
    chk("overlap", 32'h3, d);
    wait_clear(adms_pkg::STAT_BUSY_BIT);
    ncv++;
    rd(A_RES);
    chk("result", smp(k), d);
    chk("starts", 32'(ncv), 32'(starts));
    wait_clear(adms_pkg::STAT_SETTLE_BIT);
    rd(A_IST);
    chk("both events", 32'h3, d);
    wr(A_IST, 32'h3, 4'h1);
    wr(A_CTRL, 32'h100, 4'h3);
    wait_clear(adms_pkg::STAT_SETTLE_BIT);
    k = ncv;
    conv();
    conv();
    rd(A_RES);
    chk("pipe result", smp(k), d);
  endtask
  task automatic t_auto;
    int k;
    wr(A_IST, 32'h3, 4'h1);
    wr(A_MSK, 32'h0, 4'h1);
    k = ncv;
    wr(A_CTRL, 32'h83, 4'h3);
    rd(A_STAT);
    chk("auto busy", 32'h2, d & 32'h2);
    wait_clear(adms_pkg::STAT_BUSY_BIT);
    ncv++;
    rd(A_RES);
    chk("auto result", smp(k), d);
    rd(A_IST);
    chk("auto event", 32'h2, d);
    @(negedge ref_clk);
    chk("masked", 32'h3, {29'h0, irq, settling_done_irq_n, data_ready_irq_n});
    wr(A_MSK, 32'h2, 4'h1);
    @(negedge ref_clk);
    chk("unmasked", 32'h6, {29'h0, irq, settling_done_irq_n, data_ready_irq_n});
    wr(A_IST, 32'h2, 4'h1);
    @(negedge ref_clk);
    chk("cleared", 32'h3, {29'h0, irq, settling_done_irq_n, data_ready_irq_n});
    k = ncv;
    wr(A_CTRL, 32'h180, 4'h3);
    wait_clear(adms_pkg::STAT_BUSY_BIT);
    wr(A_CTRL, 32'h180, 4'h3);
    wait_clear(adms_pkg::STAT_BUSY_BIT);
    ncv += 2;
    rd(A_RES);
    chk("auto pipe result", smp(k), d);
    chk("starts", 32'(ncv), 32'(starts));
  endtask

  task automatic conclude;
    if (num_errors == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    #300000;
    num_errors++;
    conclude();
  end
  initial begin
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset();
    t_dummy();
    t_host();
    t_auto();
    conclude();
  end
endmodule
